// file: logic/pdq_pkg.sv
// Purpose: constants and types of the packet dma and its queues
// Assumes: one clock, apb registers, 16-bit memory words
// Notes: offsets are apb byte addresses; limits in bytes and collisions
//
// Summary of operation
// - transmit starts only with run flag and a queued number
// - own 11-bit address counters for transmit and receive
// - allocate on receive active; keep number, write while fifo has data
// - address miss frees the frame and stops reception
// - good crc queues the number; bad crc only frees memory
// - accept-bad-crc flag queues bad-crc frames too
// - free-on-success frees sent frames, skips completion queue
// - over 1532 bytes: stop, flag oversize abort, free memory
// - failed allocation: overrun on fifo full, flush on next frame
// - byte count heads receive buffer, status heads transmit buffer
// - restart after each collision while under 16 retries
// - enqueue command pushes packet number register to transmit queue
// - dma pops transmit queue for mac; status shows it empty
// - completion head at ports; host ack removes it
// - receive number pushed only for complete frames with good crc or the accept-bad-crc flag; head at ports
// - host pops receive head; one command also frees memory
// - each queue 5 bits wide, 18 entries deep
// - enqueue takes any packet number in any order
// - transmit and receive memory requests never overlap
// - 16th collision: stop, clear run flag, number to completion
// - transmit-done status set while completion queue not empty
package pdq_pkg;
    localparam int QW = 5;
    localparam int QD = 18;
    localparam int AW = 11;
    localparam int RETRY_MAX = 16;
    localparam int RX_MAX_BYTES = 1532;
    localparam int QTX = 0;
    localparam int QDONE = 1;
    localparam int QRX = 2;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STAT = 12'h004;
    localparam logic [11:0] REG_PNR = 12'h008;
    localparam logic [11:0] REG_CMD = 12'h00c;
    localparam logic [11:0] REG_QPORT = 12'h010;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam int CTRL_TX_RUN = 0;
    localparam int CTRL_RX_RUN = 1;
    localparam int CTRL_BAD_CRC = 2;
    localparam int CTRL_AUTO_FREE = 3;
    localparam int CTRL_ZERO_STALL = 4;
    localparam int ST_TXDONE = 0;
    localparam int ST_TXEMPTY = 1;
    localparam int ST_RXREADY = 2;
    localparam int ST_OVR = 3;
    localparam int ST_ABORT = 4;
    localparam int CMD_ENQ = 0;
    localparam int CMD_TXACK = 1;
    localparam int CMD_RXPOP = 2;
    localparam int CMD_RXFREE = 3;
    localparam int QP_TXD_EMPTY = 7;
    localparam int QP_RX_LSB = 8;
    localparam int QP_RX_EMPTY = 15;
    localparam logic [10:0] TX_STAT_OFS = 11'h000;
    localparam logic [10:0] RX_CNT_OFS = 11'h002;
    localparam logic [10:0] DATA_OFS = 11'h004;
    localparam logic [10:0] WORD_STEP = 11'h002;
    typedef enum logic [3:0] {
        PDQ_T_IDLE = 4'b0001,
        PDQ_T_DATA = 4'b0010,
        PDQ_T_STAT = 4'b0100,
        PDQ_T_DONE = 4'b1000
    } pdq_tx_state_t;
    typedef enum logic [4:0] {
        PDQ_R_IDLE = 5'b00001,
        PDQ_R_ALLOC = 5'b00010,
        PDQ_R_DATA = 5'b00100,
        PDQ_R_CNT = 5'b01000,
        PDQ_R_WAIT = 5'b10000
    } pdq_rx_state_t;
endpackage

// file: logic/pdq_dma.sv
// Purpose: packet dma engine and its three number queues
// Assumes: mac, arbiter and memory manager run on pclk
// Notes: one shared memory request port; transmit and receive take turns
`timescale 1ns/100ps
module pdq_dma
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mac_tx_ready,
    input wire logic mac_tx_word_req,
    input wire logic mac_tx_collision,
    input wire logic mac_tx_done,
    input wire logic mac_tx_ok,
    input wire logic [15:0] mac_tx_status,
    output logic mac_tx_start,
    input wire logic mac_rx_active,
    input wire logic mac_rx_fifo_empty,
    input wire logic mac_rx_fifo_full,
    input wire logic [15:0] mac_rx_data,
    input wire logic mac_rx_addr_miss,
    input wire logic mac_rx_done,
    input wire logic mac_rx_crc_ok,
    output logic mac_rx_pop,
    output logic mac_rx_flush,
    output logic arb_req,
    output logic arb_write,
    output logic [4:0] arb_pnum,
    output logic [10:0] arb_addr,
    output logic [15:0] arb_wdata,
    input wire logic arb_ack,
    output logic mm_alloc_req,
    input wire logic mm_alloc_ack,
    input wire logic mm_alloc_ok,
    input wire logic [4:0] mm_alloc_num,
    output logic mm_free_req,
    output logic [4:0] mm_free_num
);
    // apb slave: one cycle of setup, answer ready in the access phase
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [4:0] ctrl_q;
    logic [4:0] pnr_q;
    logic ovr_q;
    logic abort_q;
    wire apb_setup = psel & ~penable;
    wire apb_done = psel & penable & pready_q;
    wire wr_en = apb_done & pwrite;
    wire hit_ctrl = paddr == pdq_pkg::REG_CTRL;
    wire hit_stat = paddr == pdq_pkg::REG_STAT;
    wire hit_pnr = paddr == pdq_pkg::REG_PNR;
    wire hit_cmd = paddr == pdq_pkg::REG_CMD;
    wire hit_qport = paddr == pdq_pkg::REG_QPORT;
    wire mapped = hit_ctrl | hit_stat | hit_pnr | hit_cmd | hit_qport;
    wire cmd_wr = wr_en & hit_cmd;
    wire cmd_enq = cmd_wr & pwdata[pdq_pkg::CMD_ENQ];
    wire cmd_txack = cmd_wr & pwdata[pdq_pkg::CMD_TXACK];
    wire cmd_rxpop = cmd_wr & (pwdata[pdq_pkg::CMD_RXPOP]
        | pwdata[pdq_pkg::CMD_RXFREE]);
    wire cmd_rxfree = cmd_wr & pwdata[pdq_pkg::CMD_RXFREE];
    wire stat_wr = wr_en & hit_stat;

    // packet-number queues: 0 transmit, 1 completion, 2 receive
    logic [4:0] q_mem_q [3][pdq_pkg::QD];
    logic [4:0] q_cnt_q [3];
    logic [2:0] q_push;
    logic [2:0] q_pop;
    logic [2:0] q_empty;
    logic [4:0] q_din [3];
    logic [4:0] q_head [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_q
            wire pop_ok = q_pop[g] & ~q_empty[g];
            wire push_ok = q_push[g]
                & ((q_cnt_q[g] != 5'(pdq_pkg::QD)) | pop_ok);
            wire [4:0] wpos = q_cnt_q[g] - {4'h0, pop_ok};
            assign q_empty[g] = q_cnt_q[g] == 5'h00;
            assign q_head[g] = q_mem_q[g][0];
            // shift queue keeps the head at entry 0, so no read pointer
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    q_cnt_q[g] <= 5'h00;
                    for (int i = 0; i < pdq_pkg::QD; i++)
                        q_mem_q[g][i] <= 5'h00;
                end
                else
                begin
                    q_cnt_q[g] <= wpos + {4'h0, push_ok};
                    for (int i = 0; i < pdq_pkg::QD; i++)
                        if (push_ok && wpos == 5'(i))
                            q_mem_q[g][i] <= q_din[g];
                        else if (pop_ok && i < pdq_pkg::QD - 1)
                            q_mem_q[g][i] <= q_mem_q[g][i + 1];
                end
            end
        end
    endgenerate

    // shared memory request port
    logic arb_req_q;
    logic arb_owner_rx_q;
    logic arb_gap_q;
    logic arb_last_rx_q;
    logic arb_write_q;
    logic [4:0] arb_pnum_q;
    logic [10:0] arb_addr_q;
    logic [15:0] arb_wdata_q;
    logic tx_want;
    logic rx_want;
    logic tx_wr;
    logic [10:0] tx_req_addr;
    logic [10:0] rx_req_addr;
    logic [15:0] rx_req_data;
    // gap cycle lets the mac drop its request
    wire arb_free = ~arb_req_q & ~arb_gap_q;
    wire pick_rx = rx_want & (~tx_want | ~arb_last_rx_q);
    wire arb_fin = arb_req_q & arb_ack;
    wire served_tx = arb_fin & ~arb_owner_rx_q;
    wire served_rx = arb_fin & arb_owner_rx_q;

    // transmit side
    pdq_pkg::pdq_tx_state_t tx_st_q;
    logic [4:0] tx_num_q;
    logic [10:0] tx_addr_q;
    logic [3:0] retry_q;
    logic tx_ok_q;
    logic tx_start_q;
    wire auto_free = ctrl_q[pdq_pkg::CTRL_AUTO_FREE];
    wire tx_go = ctrl_q[pdq_pkg::CTRL_TX_RUN] & ~q_empty[pdq_pkg::QTX]
        & mac_tx_ready;
    wire last_retry = retry_q == 4'(pdq_pkg::RETRY_MAX - 1);
    wire tx_fin = tx_st_q == pdq_pkg::PDQ_T_DONE;
    wire tx_free = tx_fin & tx_ok_q & auto_free;
    assign tx_want = (tx_st_q == pdq_pkg::PDQ_T_DATA & mac_tx_word_req)
        | tx_st_q == pdq_pkg::PDQ_T_STAT;
    assign tx_wr = tx_st_q == pdq_pkg::PDQ_T_STAT;
    assign tx_req_addr = tx_wr ? pdq_pkg::TX_STAT_OFS : tx_addr_q;

    // receive side
    pdq_pkg::pdq_rx_state_t rx_st_q;
    logic [4:0] rx_num_q;
    logic [10:0] rx_addr_q;
    logic [10:0] rx_cnt_q;
    logic rx_end_q;
    logic rx_crc_q;
    logic nomem_q;
    logic alloc_q;
    logic flush_q;
    logic pop_q;
    wire rx_data_st = rx_st_q == pdq_pkg::PDQ_R_DATA;
    wire rx_cnt_st = rx_st_q == pdq_pkg::PDQ_R_CNT;
    wire rx_big = rx_cnt_q > 11'(pdq_pkg::RX_MAX_BYTES);
    wire rx_keep = rx_crc_q | ctrl_q[pdq_pkg::CTRL_BAD_CRC];
    wire rx_busy = (arb_req_q & arb_owner_rx_q) | arb_gap_q | pop_q;
    wire rx_drained = rx_end_q & mac_rx_fifo_empty & ~rx_busy;
    wire rx_cnt_done = rx_cnt_st & served_rx;
    wire rx_drop = rx_data_st & (mac_rx_addr_miss | rx_big);
    wire rx_free = rx_drop | (rx_cnt_done & ~rx_keep);
    assign rx_want = (rx_data_st & ~mac_rx_fifo_empty & ~rx_big
        & ~rx_busy) | rx_cnt_st;
    assign rx_req_addr = rx_cnt_st ? pdq_pkg::RX_CNT_OFS : rx_addr_q;
    assign rx_req_data = rx_cnt_st ? {5'h00, rx_cnt_q}
        : mac_rx_data;

    // queue hookup
    assign q_push[pdq_pkg::QTX] = cmd_enq;
    assign q_din[pdq_pkg::QTX] = pnr_q;
    assign q_pop[pdq_pkg::QTX] = tx_fin;
    assign q_push[pdq_pkg::QDONE] = tx_fin & ~tx_free;
    assign q_din[pdq_pkg::QDONE] = tx_num_q;
    assign q_pop[pdq_pkg::QDONE] = cmd_txack;
    assign q_push[pdq_pkg::QRX] = rx_cnt_done & rx_keep;
    assign q_din[pdq_pkg::QRX] = rx_num_q;
    assign q_pop[pdq_pkg::QRX] = cmd_rxpop;

    // register read mux
    wire [31:0] stat_word = {27'h000_0000, abort_q, ovr_q,
        ~q_empty[pdq_pkg::QRX], q_empty[pdq_pkg::QTX],
        ~q_empty[pdq_pkg::QDONE]};
    // empty queues read as zero number plus an empty bit
    wire [4:0] txd_num = q_empty[pdq_pkg::QDONE] ? 5'h00
        : q_head[pdq_pkg::QDONE];
    wire [4:0] rx_num_rd = q_empty[pdq_pkg::QRX] ? 5'h00
        : q_head[pdq_pkg::QRX];
    wire [31:0] qport_word = {16'h0000, q_empty[pdq_pkg::QRX], 2'b00,
        rx_num_rd, q_empty[pdq_pkg::QDONE], 2'b00, txd_num};
    wire [31:0] rd_mux = hit_ctrl ? {27'h000_0000, ctrl_q}
        : hit_stat ? stat_word
        : hit_pnr ? {27'h000_0000, pnr_q}
        : hit_qport ? qport_word
        : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup & ~mapped;
            prdata_q <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // a hardware stop of transmit loses to a host write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= pdq_pkg::CTRL_RST;
            pnr_q <= 5'h00;
            ovr_q <= 1'b0;
            abort_q <= 1'b0;
        end
        else
        begin
            if (wr_en && hit_ctrl)
                ctrl_q <= pwdata[4:0];
            else if (tx_fin && !tx_ok_q)
                ctrl_q[pdq_pkg::CTRL_TX_RUN] <= 1'b0;
            if (wr_en && hit_pnr)
                pnr_q <= pwdata[4:0];
            // flags clear by writing one; a new event in that cycle wins
            ovr_q <= (nomem_q & mac_rx_fifo_full)
                | (ovr_q & ~(stat_wr & pwdata[pdq_pkg::ST_OVR]));
            abort_q <= (rx_data_st & rx_big)
                | (abort_q & ~(stat_wr & pwdata[pdq_pkg::ST_ABORT]));
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arb_req_q <= 1'b0;
            arb_owner_rx_q <= 1'b0;
            arb_gap_q <= 1'b0;
            arb_last_rx_q <= 1'b0;
            arb_write_q <= 1'b0;
            arb_pnum_q <= 5'h00;
            arb_addr_q <= 11'h000;
            arb_wdata_q <= 16'h0000;
        end
        else
        begin
            arb_gap_q <= arb_fin;
            if (arb_fin)
            begin
                arb_req_q <= 1'b0;
                arb_last_rx_q <= arb_owner_rx_q;
            end
            else if (arb_free && (tx_want || rx_want))
            begin
                arb_req_q <= 1'b1;
                arb_owner_rx_q <= pick_rx;
                arb_write_q <= pick_rx | tx_wr;
                arb_pnum_q <= pick_rx ? rx_num_q : q_head[pdq_pkg::QTX];
                arb_addr_q <= pick_rx ? rx_req_addr : tx_req_addr;
                arb_wdata_q <= pick_rx ? rx_req_data : mac_tx_status;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st_q <= pdq_pkg::PDQ_T_IDLE;
            tx_num_q <= 5'h00;
            tx_addr_q <= 11'h000;
            retry_q <= 4'h0;
            tx_ok_q <= 1'b0;
            tx_start_q <= 1'b0;
        end
        else
        begin
            tx_start_q <= 1'b0;
            unique case (tx_st_q)
                pdq_pkg::PDQ_T_IDLE:
                    if (tx_go)
                    begin
                        tx_st_q <= pdq_pkg::PDQ_T_DATA;
                        tx_num_q <= q_head[pdq_pkg::QTX];
                        tx_addr_q <= pdq_pkg::DATA_OFS;
                        retry_q <= 4'h0;
                        tx_start_q <= 1'b1;
                    end
                pdq_pkg::PDQ_T_DATA:
                    if (mac_tx_collision && last_retry)
                    begin
                        tx_ok_q <= 1'b0;
                        tx_st_q <= pdq_pkg::PDQ_T_STAT;
                    end
                    else if (mac_tx_collision)
                    begin
                        retry_q <= retry_q + 4'h1;
                        tx_addr_q <= pdq_pkg::DATA_OFS;
                        tx_start_q <= 1'b1;
                    end
                    else if (mac_tx_done)
                    begin
                        tx_ok_q <= mac_tx_ok;
                        tx_st_q <= pdq_pkg::PDQ_T_STAT;
                    end
                    else if (served_tx)
                        tx_addr_q <= tx_addr_q + pdq_pkg::WORD_STEP;
                pdq_pkg::PDQ_T_STAT:
                    if (served_tx)
                        tx_st_q <= pdq_pkg::PDQ_T_DONE;
                pdq_pkg::PDQ_T_DONE:
                    tx_st_q <= pdq_pkg::PDQ_T_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_q <= pdq_pkg::PDQ_R_IDLE;
            rx_num_q <= 5'h00;
            rx_addr_q <= 11'h000;
            rx_cnt_q <= 11'h000;
            rx_end_q <= 1'b0;
            rx_crc_q <= 1'b0;
            nomem_q <= 1'b0;
            alloc_q <= 1'b0;
            flush_q <= 1'b0;
            pop_q <= 1'b0;
        end
        else
        begin
            alloc_q <= 1'b0;
            flush_q <= 1'b0;
            pop_q <= served_rx & rx_data_st;
            unique case (rx_st_q)
                pdq_pkg::PDQ_R_IDLE:
                    if (ctrl_q[pdq_pkg::CTRL_RX_RUN] && mac_rx_active)
                    begin
                        alloc_q <= 1'b1;
                        flush_q <= nomem_q;
                        nomem_q <= 1'b0;
                        rx_st_q <= pdq_pkg::PDQ_R_ALLOC;
                    end
                pdq_pkg::PDQ_R_ALLOC:
                    if (mm_alloc_ack && mm_alloc_ok)
                    begin
                        rx_num_q <= mm_alloc_num;
                        rx_addr_q <= pdq_pkg::DATA_OFS;
                        rx_cnt_q <= 11'h000;
                        rx_end_q <= 1'b0;
                        rx_st_q <= pdq_pkg::PDQ_R_DATA;
                    end
                    else if (mm_alloc_ack)
                    begin
                        nomem_q <= 1'b1;
                        rx_st_q <= pdq_pkg::PDQ_R_WAIT;
                    end
                pdq_pkg::PDQ_R_DATA:
                begin
                    if (served_rx)
                    begin
                        rx_addr_q <= rx_addr_q + pdq_pkg::WORD_STEP;
                        rx_cnt_q <= rx_cnt_q + pdq_pkg::WORD_STEP;
                    end
                    if (mac_rx_done)
                    begin
                        rx_end_q <= 1'b1;
                        rx_crc_q <= mac_rx_crc_ok;
                    end
                    if (rx_drop)
                        rx_st_q <= pdq_pkg::PDQ_R_WAIT;
                    else if (rx_drained)
                        rx_st_q <= pdq_pkg::PDQ_R_CNT;
                end
                pdq_pkg::PDQ_R_CNT:
                    if (served_rx)
                        rx_st_q <= pdq_pkg::PDQ_R_WAIT;
                pdq_pkg::PDQ_R_WAIT:
                    if (!mac_rx_active)
                        rx_st_q <= pdq_pkg::PDQ_R_IDLE;
            endcase
        end
    end

    // releases may clash, so each waits its turn
    logic fp_tx_q;
    logic fp_rx_q;
    logic fp_host_q;
    logic [4:0] fn_tx_q;
    logic [4:0] fn_rx_q;
    logic [4:0] fn_host_q;
    logic free_q;
    logic [4:0] free_num_q;
    wire iss_rx = fp_rx_q;
    wire iss_tx = fp_tx_q & ~fp_rx_q;
    wire iss_host = fp_host_q & ~fp_rx_q & ~fp_tx_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fp_tx_q <= 1'b0;
            fp_rx_q <= 1'b0;
            fp_host_q <= 1'b0;
            fn_tx_q <= 5'h00;
            fn_rx_q <= 5'h00;
            fn_host_q <= 5'h00;
            free_q <= 1'b0;
            free_num_q <= 5'h00;
        end
        else
        begin
            fp_tx_q <= tx_free | (fp_tx_q & ~iss_tx);
            fp_rx_q <= rx_free | (fp_rx_q & ~iss_rx);
            fp_host_q <= (cmd_rxfree & ~q_empty[pdq_pkg::QRX])
                | (fp_host_q & ~iss_host);
            if (tx_free)
                fn_tx_q <= tx_num_q;
            if (rx_free)
                fn_rx_q <= rx_num_q;
            if (cmd_rxfree)
                fn_host_q <= q_head[pdq_pkg::QRX];
            free_q <= iss_rx | iss_tx | iss_host;
            free_num_q <= iss_rx ? fn_rx_q : iss_tx ? fn_tx_q : fn_host_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mac_tx_start = tx_start_q;
    assign mac_rx_pop = pop_q;
    assign mac_rx_flush = flush_q;
    assign arb_req = arb_req_q;
    assign arb_write = arb_write_q;
    assign arb_pnum = arb_pnum_q;
    assign arb_addr = arb_addr_q;
    assign arb_wdata = arb_wdata_q;
    assign mm_alloc_req = alloc_q;
    assign mm_free_req = free_q;
    assign mm_free_num = free_num_q;
endmodule

// file: dv/pdq_far.sv
// Purpose: arbiter and memory manager stand-in for the dma
// Assumes: one clock; arbiter grants come three cycles after a request, allocation answers the next cycle
// Notes: number bus is garbage outside an answer
`timescale 1ns/100ps
module pdq_far
(
    input logic pclk,
    input logic presetn,
    input logic arb_req,
    input logic mm_alloc_req,
    output logic arb_ack,
    output logic mm_alloc_ack,
    output logic mm_alloc_ok,
    output logic [4:0] mm_alloc_num
);
    logic [1:0] w_q;
    logic [4:0] n_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            w_q <= 2'h0;
            n_q <= 5'h03;
            arb_ack <= 1'b0;
            mm_alloc_ack <= 1'b0;
            mm_alloc_ok <= 1'b0;
            mm_alloc_num <= 5'h00;
        end
        else
        begin
            // slow grant: the host side may own the memory meanwhile
            w_q <= (arb_req && !arb_ack) ? w_q + 2'h1 : 2'h0;
            arb_ack <= arb_req && !arb_ack && w_q == 2'h2;
            mm_alloc_ack <= mm_alloc_req;
            mm_alloc_ok <= mm_alloc_req;
            mm_alloc_num <= mm_alloc_req ? n_q : ~n_q;
            if (mm_alloc_req)
                n_q <= n_q + 5'h05;
        end
    end
endmodule

// file: dv/pdq_dma_sva.sv
// Purpose: port checks of the packet dma
// Assumes: single clock, asynchronous low reset
// Notes: run flags are internal, so checks tie outputs to input causes
`timescale 1ns/100ps
module pdq_dma_sva
(
    input logic pclk,
    input logic presetn,
    input logic mac_tx_ready,
    input logic mac_tx_start,
    input logic mac_rx_active,
    input logic mac_rx_addr_miss,
    input logic mac_rx_pop,
    input logic arb_req,
    input logic arb_write,
    input logic [10:0] arb_addr,
    input logic arb_ack,
    input logic mm_alloc_req,
    input logic mm_free_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_start_mac_ready: assert property (
        mac_tx_start |-> $past(mac_tx_ready))
        else $error("start without ready");
    a_start_pulse: assert property (
        mac_tx_start |=> !mac_tx_start)
        else $error("start too long");
    a_alloc_on_active: assert property (
        mm_alloc_req |-> $past(mac_rx_active))
        else $error("alloc while idle");
    a_pop_after_write: assert property (
        arb_ack && arb_write && arb_addr >= 11'h004 |=> mac_rx_pop)
        else $error("no pop after write");
    a_pop_has_cause: assert property (
        mac_rx_pop |-> $past(arb_ack) && $past(arb_write))
        else $error("pop without write");
    a_miss_frees: assert property (
        mac_rx_addr_miss |-> ##[1:12] mm_free_req)
        else $error("no release on miss");
    a_req_held: assert property (
        arb_req && !arb_ack |=> arb_req && $stable(arb_addr)
        && $stable(arb_write))
        else $error("request not held");
    a_word_align: assert property (arb_req |-> !arb_addr[0])
        else $error("odd address");
endmodule
bind pdq_dma pdq_dma_sva u_pdq_dma_sva (.*);

// file: dv/tb_top.sv
// Purpose: self-checking bench for the packet dma
// Assumes: apb and mac driven here, memory side in pdq_far
// Notes: fixed seed; short frames keep the run brief
`timescale 1ns/100ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mac_tx_ready, mac_tx_word_req, mac_tx_collision, mac_tx_done;
    logic mac_tx_ok, mac_tx_start, mac_rx_active, mac_rx_fifo_empty;
    logic mac_rx_fifo_full, mac_rx_addr_miss, mac_rx_done, mac_rx_crc_ok;
    logic mac_rx_pop, mac_rx_flush, arb_req, arb_write, arb_ack;
    logic mm_alloc_req, mm_alloc_ack, mm_alloc_ok, mm_free_req;
    logic [15:0] mac_tx_status, mac_rx_data, arb_wdata;
    logic [15:0] wcap [2];
    logic [10:0] arb_addr;
    logic [4:0] arb_pnum, mm_alloc_num, mm_free_num, last_free, rx_num;
    logic [4:0] p0, p1, q;
    int mismatches, samples_checked, cyc, starts, rx_left;
    pdq_dma u_pdq_dma (.*);
    pdq_far u_pdq_far (.*);
    assign mac_rx_fifo_empty = rx_left == 0;
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        mac_rx_data <= 16'($urandom);
        if (mac_tx_start)
            starts <= starts + 1;
        if (mac_rx_pop)
            rx_left <= rx_left - 1;
        if (arb_ack)
            mac_tx_word_req <= 1'b0;
        if (mm_free_req)
            last_free <= mm_free_num;
        if (mm_alloc_ack)
            rx_num <= mm_alloc_num;
        if (arb_ack && arb_write && arb_addr < 11'h004)
            wcap[arb_addr[1]] <= arb_wdata;
        if (cyc == 5000)
        begin
            mismatches++;
            end_sim;
        end
    end
    task automatic end_sim;
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // collisions first; 16 of them leave the frame unsent
    task automatic tx_frame(input int ncol);
        while (mac_tx_start !== 1'b1)
            @(posedge pclk);
        for (int k = 0; k < ncol; k++)
        begin
            mac_tx_collision <= 1'b1;
            @(posedge pclk);
            mac_tx_collision <= 1'b0;
            idle(6);
        end
        if (ncol < 16)
        begin
            mac_tx_word_req <= 1'b1;
            idle(8);
            mac_tx_status <= 16'($urandom);
            mac_tx_ok <= 1'b1;
            mac_tx_done <= 1'b1;
            @(posedge pclk);
            mac_tx_done <= 1'b0;
        end
        idle(12);
    endtask
    task automatic rx_frame(input int words, input logic crc,
        input logic miss);
        mac_rx_active <= 1'b1;
        rx_left <= words;
        idle(6);
        mac_rx_addr_miss <= miss;
        @(posedge pclk);
        mac_rx_addr_miss <= 1'b0;
        while (rx_left != 0)
            @(posedge pclk);
        idle(4);
        mac_rx_crc_ok <= crc;
        mac_rx_done <= !miss;
        @(posedge pclk);
        mac_rx_done <= 1'b0;
        mac_rx_active <= 1'b0;
        idle(16);
    endtask
    initial
    begin
        {psel, penable, pwrite, mac_tx_collision, mac_tx_done, mac_tx_ok,
            mac_rx_active, mac_rx_fifo_full, mac_rx_addr_miss, mac_rx_done,
            mac_rx_crc_ok, mac_tx_word_req} = '0;
        {paddr, pwdata, mac_tx_status, mac_rx_data} = '0;
        presetn = 1'b0;
        mac_tx_ready = 1'b1;
        void'($urandom(1033));
        idle(3);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, pdq_pkg::REG_STAT, 0);
        chk(rd, 32'h0000_0002);
        apb(0, 12'h014, 0);
        chk(32'(err), 32'h0000_0001);
        p0 = 5'($urandom);
        p1 = p0 + 5'h0b;
        apb(1, pdq_pkg::REG_PNR, 32'(p0));
        apb(1, pdq_pkg::REG_CMD, 32'h0000_0001);
        apb(0, pdq_pkg::REG_STAT, 0);
        chk(rd, 32'h0000_0000);
        mac_tx_ready <= 1'b0;
        apb(1, pdq_pkg::REG_CTRL, 32'h0000_0001);
        idle(4);
        chk(32'(starts), 32'h0000_0000);
        mac_tx_ready <= 1'b1;
        tx_frame(2);
        chk(32'(starts), 32'h0000_0003);
        chk(32'(wcap[0]), 32'(mac_tx_status));
        apb(0, pdq_pkg::REG_QPORT, 0);
        chk(32'({rd[15], rd[7:0]}), 32'({4'h8, p0}));
        apb(0, pdq_pkg::REG_STAT, 0);
        chk(rd, 32'h0000_0003);
        apb(1, pdq_pkg::REG_CTRL, 32'h0000_0009);
        apb(1, pdq_pkg::REG_PNR, 32'(p1));
        apb(1, pdq_pkg::REG_CMD, 32'h0000_0001);
        tx_frame(0);
        chk(32'(last_free), 32'(p1));
        apb(1, pdq_pkg::REG_CMD, 32'h0000_0002);
        apb(0, pdq_pkg::REG_QPORT, 0);
        chk(32'(rd[7:0]), 32'h0000_0080);
        apb(1, pdq_pkg::REG_CMD, 32'h0000_0001);
        tx_frame(16);
        chk(32'(starts), 32'h0000_0014);
        apb(0, pdq_pkg::REG_QPORT, 0);
        chk(32'(rd[7:0]), 32'(p1));
        apb(0, pdq_pkg::REG_CTRL, 0);
        chk(rd, 32'h0000_0008);
        apb(1, pdq_pkg::REG_CTRL, 32'h0000_0002);
        rx_frame(4, 1'b1, 1'b0);
        q = rx_num;
        chk(32'(wcap[1]), 32'h0000_0008);
        apb(0, pdq_pkg::REG_QPORT, 0);
        chk(32'({rd[15], rd[12:8]}), 32'(q));
        rx_frame(2, 1'b0, 1'b0);
        chk(32'(last_free), 32'(rx_num));
        rx_frame(0, 1'b1, 1'b1);
        chk(32'(last_free), 32'(rx_num));
        apb(1, pdq_pkg::REG_CTRL, 32'h0000_0006);
        rx_frame(2, 1'b0, 1'b0);
        apb(1, pdq_pkg::REG_CMD, 32'h0000_0008);
        idle(4);
        chk(32'(last_free), 32'(q));
        apb(0, pdq_pkg::REG_QPORT, 0);
        chk(32'({rd[15], rd[12:8]}), 32'(rx_num));
        apb(1, pdq_pkg::REG_CMD, 32'h0000_0004);
        apb(0, pdq_pkg::REG_QPORT, 0);
        chk(32'(rd[15]), 32'h0000_0001);
        end_sim;
    end
endmodule
